// ---- inc/tam_pkg.sv ----
// Constants for the T1 alarm mask and line front-end control register bank.
// Assumes a single 50 MHz system clock and an Avalon-MM master on the bus side.
package tam_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_IRQ_MASK   = 8'h1E;
  localparam logic [7:0] IDX_LINE_CTRL  = 8'h1F;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_MODE_CTRL  = 8'h21;
  localparam int         ADDR_W         = 10;
  // Mask and status bit positions
  localparam int EV_SIG  = 0;
  localparam int EV_BOM  = 1;
  localparam int EV_FIVE = 2;
  localparam int EV_ONE  = 3;
  localparam int EV_LOOP = 4;
  localparam int EV_N    = 5;
  // Line control fields
  localparam int LC_NRZ     = 7;
  localparam int LC_TXL_LSB = 4;
  localparam int LC_EQ_OFF  = 3;
  localparam int LC_RES_LSB = 0;
  localparam logic [7:0] LINE_CTRL_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST  = 8'h00;
  // Mode control bits
  localparam int MC_DBE    = 0;
  localparam int MC_LIU_DIS = 1;
  // Bit-oriented message window
  localparam int BOM_WIN    = 10;
  localparam int BOM_ACCEPT = 8;
  localparam int BOM_W      = 6;
  // Timing
  localparam longint CLK_HZ      = 50_000_000;
  localparam longint LOOP_MS     = 48;
  localparam longint LOOP_CYC    = LOOP_MS * CLK_HZ / 1000;
  localparam longint DEBOUNCE_MS = 16;
  localparam longint DEBOUNCE_CYC = DEBOUNCE_MS * CLK_HZ / 1000;
endpackage : tam_pkg

// ---- verilog/tam_alarm_line_ctrl.sv ----
// Interrupt mask word three and line front-end control, with event detection.
// Assumes event inputs come from framer logic on ref_clk_i; line pins are asynchronous.
`timescale 1ns/10ps
module tam_alarm_line_ctrl
  import tam_pkg::*;
#(
  parameter int LOOP_CYCLES   = int'(LOOP_CYC),
  parameter int DEBOUNCE_CYCLES = int'(DEBOUNCE_CYC)
) (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              arst_n_i,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // Framer event sources
  input  wire logic              loop_code_present_i,
  input  wire logic              one_second_flag_i,
  input  wire logic              five_second_flag_i,
  input  wire logic              bom_strobe_i,
  input  wire logic [BOM_W-1:0]  bom_code_i,
  input  wire logic [3:0]        sig_bits_i,
  // Framer data
  input  wire logic              tx_pos_i,
  input  wire logic              tx_neg_i,
  output logic                   rx_pos_o,
  output logic                   rx_neg_o,
  // Line pins in framer-only mode
  input  wire logic              line_in_first_i,
  input  wire logic              line_in_second_i,
  output logic                   line_out_first_o,
  output logic                   line_out_second_o,
  // Analog front-end controls
  output logic                   liu_disable_o,
  output logic      [2:0]        tx_build_out_select_o,
  output logic                   rx_equalizer_off_o,
  output logic      [2:0]        rx_equalization_level_o,
  output logic                   rx_eq_forced_o,
  // Interrupt
  output logic                   irq_o
);

  logic [7:0]       irq_mask_reg;
  logic [7:0]       line_ctrl_reg;
  logic [EV_N-1:0]  irq_status_reg;
  logic [1:0]       mode_ctrl_reg;
  logic             ack_reg;
  logic [EV_N-1:0]  event_pulse;

  // Bus handshake: every access takes one wait cycle
  logic [7:0] reg_idx;
  logic       wr_go;
  assign reg_idx           = avs_address_i[ADDR_W-1:2];
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  assign wr_go             = avs_write_i & ack_reg & avs_byteenable_i[0];

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack_reg) begin
      case (reg_idx)
        IDX_IRQ_MASK:   avs_readdata_o <= {24'h00_0000, irq_mask_reg};
        IDX_LINE_CTRL:  avs_readdata_o <= {24'h00_0000, line_ctrl_reg};
        IDX_IRQ_STATUS: avs_readdata_o <= {27'h000_0000, irq_status_reg};
        IDX_MODE_CTRL:  avs_readdata_o <= {30'h0000_0000, mode_ctrl_reg};
        default:        avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Writable registers; unused mask bits always read zero
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_mask_reg  <= IRQ_MASK_RST;
      line_ctrl_reg <= LINE_CTRL_RST;
      mode_ctrl_reg <= 2'b00;
    end else if (wr_go) begin
      case (reg_idx)
        IDX_IRQ_MASK:  irq_mask_reg  <= {3'b000, avs_writedata_i[EV_N-1:0]};
        IDX_LINE_CTRL: line_ctrl_reg <= avs_writedata_i[7:0];
        IDX_MODE_CTRL: mode_ctrl_reg <= avs_writedata_i[1:0];
        default:       ;
      endcase
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_status_reg <= '0;
    end else begin
      if (wr_go && reg_idx == IDX_IRQ_STATUS) begin
        irq_status_reg <= (irq_status_reg & ~avs_writedata_i[EV_N-1:0]) | event_pulse;
      end else begin
        irq_status_reg <= irq_status_reg | event_pulse;
      end
    end
  end

  // Status records every event; only the mask gates the request line
  assign irq_o = |(irq_status_reg & irq_mask_reg[EV_N-1:0]);

  // Loop code persistence timer
  logic [31:0] loop_cnt_reg;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loop_cnt_reg <= '0;
    end else if (!loop_code_present_i) begin
      loop_cnt_reg <= '0;
    end else if (loop_cnt_reg < 32'(LOOP_CYCLES)) begin
      loop_cnt_reg <= loop_cnt_reg + 32'd1;
    end
  end
  // One pulse per continuous presence, at the 48 ms point
  assign event_pulse[EV_LOOP] = loop_code_present_i
                              && (loop_cnt_reg == 32'(LOOP_CYCLES - 1));

  // Second flags: rising edge detection
  logic one_prev_reg;
  logic five_prev_reg;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      one_prev_reg  <= 1'b0;
      five_prev_reg <= 1'b0;
    end else begin
      one_prev_reg  <= one_second_flag_i;
      five_prev_reg <= five_second_flag_i;
    end
  end
  assign event_pulse[EV_ONE]  = one_second_flag_i & ~one_prev_reg;
  assign event_pulse[EV_FIVE] = five_second_flag_i & ~five_prev_reg;

  // Bit-oriented message: history of the last ten received codes
  logic [BOM_W-1:0] bom_hist_reg [BOM_WIN];
  logic [BOM_W-1:0] bom_accepted_reg;
  logic [3:0]       bom_fill_reg;
  logic [3:0]       bom_match;
  logic             bom_accept;
  always_comb begin
    bom_match = 4'd1;
    for (int i = 0; i < BOM_WIN - 1; i++) begin
      if (bom_hist_reg[i] == bom_code_i && 4'(i) < bom_fill_reg) begin
        bom_match = bom_match + 4'd1;
      end
    end
  end
  // Needs 8 of 10 including the current one; repeats of the accepted code are silent
  assign bom_accept = bom_strobe_i && (bom_match >= 4'(BOM_ACCEPT))
                    && (bom_code_i != bom_accepted_reg);
  assign event_pulse[EV_BOM] = bom_accept;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < BOM_WIN; i++) begin
        bom_hist_reg[i] <= '0;
      end
      bom_accepted_reg <= '0;
      bom_fill_reg     <= '0;
    end else if (bom_strobe_i) begin
      bom_hist_reg[0] <= bom_code_i;
      for (int i = 1; i < BOM_WIN; i++) begin
        bom_hist_reg[i] <= bom_hist_reg[i-1];
      end
      if (bom_fill_reg < 4'(BOM_WIN)) begin
        bom_fill_reg <= bom_fill_reg + 4'd1;
      end
      if (bom_accept) begin
        bom_accepted_reg <= bom_code_i;
      end
    end
  end

  // Signaling change with optional debounce
  logic [3:0]  sig_stable_reg;
  logic [3:0]  sig_prev_reg;
  logic [31:0] sig_db_cnt_reg;
  logic        sig_differs;
  logic        sig_commit;
  assign sig_differs = (sig_bits_i != sig_stable_reg);
  // A candidate that moves in the last window cycle must not be committed
  assign sig_commit  = sig_differs && (!mode_ctrl_reg[MC_DBE]
                    || (sig_db_cnt_reg == 32'(DEBOUNCE_CYCLES - 1)
                        && sig_bits_i == sig_prev_reg));
  assign event_pulse[EV_SIG] = sig_commit;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sig_stable_reg <= 4'h0;
      sig_db_cnt_reg <= '0;
    end else begin
      if (sig_commit) begin
        sig_stable_reg <= sig_bits_i;
      end
      // A candidate that moves again restarts the debounce window
      if (!sig_differs || sig_commit || sig_bits_i != sig_prev_reg) begin
        sig_db_cnt_reg <= '0;
      end else begin
        sig_db_cnt_reg <= sig_db_cnt_reg + 32'd1;
      end
    end
  end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sig_prev_reg <= 4'h0;
    end else begin
      sig_prev_reg <= sig_bits_i;
    end
  end

  // Line pin synchronisers
  logic [1:0] rx_meta_reg;
  logic [1:0] rx_sync_reg;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_meta_reg <= 2'b00;
      rx_sync_reg <= 2'b00;
    end else begin
      rx_meta_reg <= {line_in_second_i, line_in_first_i};
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // Framer-only line formatting; idle at zero while the internal front-end is used
  logic nrz_mode;
  assign nrz_mode = line_ctrl_reg[LC_NRZ];
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_pos_o          <= 1'b0;
      rx_neg_o          <= 1'b0;
      line_out_first_o  <= 1'b0;
      line_out_second_o <= 1'b0;
    end else if (!mode_ctrl_reg[MC_LIU_DIS]) begin
      rx_pos_o          <= 1'b0;
      rx_neg_o          <= 1'b0;
      line_out_first_o  <= 1'b0;
      line_out_second_o <= 1'b0;
    end else if (nrz_mode) begin
      rx_pos_o          <= rx_sync_reg[0];
      rx_neg_o          <= 1'b0;
      line_out_first_o  <= 1'b0;
      line_out_second_o <= tx_pos_i;
    end else begin
      rx_pos_o          <= rx_sync_reg[0];
      rx_neg_o          <= rx_sync_reg[1];
      line_out_first_o  <= tx_pos_i;
      line_out_second_o <= tx_neg_i;
    end
  end

  // Front-end control fields
  assign liu_disable_o           = mode_ctrl_reg[MC_LIU_DIS];
  assign tx_build_out_select_o   = line_ctrl_reg[LC_TXL_LSB +: 3];
  assign rx_equalizer_off_o      = line_ctrl_reg[LC_EQ_OFF];
  assign rx_eq_forced_o          = line_ctrl_reg[LC_EQ_OFF];
  // Level reads zero while automatic equalization runs
  assign rx_equalization_level_o = line_ctrl_reg[LC_EQ_OFF]
                                 ? line_ctrl_reg[LC_RES_LSB +: 3] : 3'b000;

  // Checks
  // Presence counted apart from the timer, so a broken timer cannot vouch for itself
  logic [31:0] loop_seen_reg;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loop_seen_reg <= '0;
    end else if (!loop_code_present_i) begin
      loop_seen_reg <= '0;
    end else if (loop_seen_reg != 32'(LOOP_CYCLES)) begin
      loop_seen_reg <= loop_seen_reg + 32'd1;
    end
  end

  // Events
  loop_event_time_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    event_pulse[EV_LOOP] == (loop_code_present_i && loop_seen_reg == 32'(LOOP_CYCLES - 1)))
    else $error("loop event off the presence count");
  loop_status_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    event_pulse[EV_LOOP] |=> irq_status_reg[EV_LOOP])
    else $error("loop event not recorded");
  loop_once_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    event_pulse[EV_LOOP] |=> !event_pulse[EV_LOOP])
    else $error("loop event repeated");
  one_sec_edge_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    $rose(one_second_flag_i) |=> irq_status_reg[EV_ONE])
    else $error("one-second edge not recorded");
  one_sec_hold_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    one_second_flag_i && $past(one_second_flag_i) |-> !event_pulse[EV_ONE])
    else $error("one-second event without an edge");
  five_sec_edge_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    $rose(five_second_flag_i) |=> irq_status_reg[EV_FIVE])
    else $error("five-second edge not recorded");
  five_sec_hold_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    five_second_flag_i && $past(five_second_flag_i) |-> !event_pulse[EV_FIVE])
    else $error("five-second event without an edge");
  bom_new_code_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    bom_accept |=> bom_accepted_reg == $past(bom_code_i) && irq_status_reg[EV_BOM])
    else $error("accepted message not latched");
  bom_repeat_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    bom_strobe_i && bom_code_i == bom_accepted_reg |-> !event_pulse[EV_BOM])
    else $error("repeated message raised an event");
  bom_vote_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    bom_accept |-> bom_fill_reg >= 4'(BOM_ACCEPT - 1))
    else $error("message accepted with too few positions");
  bom_history_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    bom_strobe_i |=> bom_hist_reg[0] == $past(bom_code_i))
    else $error("message position not recorded");
  sig_change_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !mode_ctrl_reg[MC_DBE] && sig_bits_i != sig_stable_reg |=> irq_status_reg[EV_SIG])
    else $error("signaling change missed");
  sig_settle_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    mode_ctrl_reg[MC_DBE] && sig_bits_i != sig_prev_reg |-> !event_pulse[EV_SIG])
    else $error("signaling change taken before it settled");
  sig_latch_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    event_pulse[EV_SIG] |=> sig_stable_reg == $past(sig_bits_i))
    else $error("signaling state not latched");

  // Mask and request
  mask_unused_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    irq_mask_reg[7:5] == 3'b000)
    else $error("unused mask bits set");
  irq_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    irq_mask_reg[EV_N-1:0] == '0 |-> !irq_o)
    else $error("request while every event masked");
  mask_read_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    avs_read_i && !ack_reg && reg_idx == IDX_IRQ_MASK |=> avs_readdata_o[31:EV_N] == '0)
    else $error("unused mask bits read back set");
  irq_gate_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    |(event_pulse & irq_mask_reg[EV_N-1:0]) && !(wr_go && reg_idx == IDX_IRQ_MASK)
    |=> irq_o)
    else $error("masked-in event raised no request");
  status_sticky_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    irq_status_reg[EV_LOOP] && !(wr_go && reg_idx == IDX_IRQ_STATUS)
    |=> irq_status_reg[EV_LOOP])
    else $error("sticky status lost");

  // Line formatting
  line_idle_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !mode_ctrl_reg[MC_LIU_DIS]
    |=> !rx_pos_o && !rx_neg_o && !line_out_first_o && !line_out_second_o)
    else $error("line outputs active with the internal front-end");
  nrz_route_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    mode_ctrl_reg[MC_LIU_DIS] && nrz_mode && $stable(line_ctrl_reg) && $stable(mode_ctrl_reg)
    |=> line_out_second_o == $past(tx_pos_i) && !line_out_first_o)
    else $error("nrz transmit routing wrong");
  nrz_rx_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    mode_ctrl_reg[MC_LIU_DIS] && nrz_mode |=> rx_pos_o == $past(rx_sync_reg[0]) && !rx_neg_o)
    else $error("nrz receive routing wrong");
  dual_rail_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    mode_ctrl_reg[MC_LIU_DIS] && !nrz_mode && $stable(line_ctrl_reg) && $stable(mode_ctrl_reg)
    |=> line_out_first_o == $past(tx_pos_i) && line_out_second_o == $past(tx_neg_i))
    else $error("dual-rail transmit routing wrong");
  dual_rx_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    mode_ctrl_reg[MC_LIU_DIS] && !nrz_mode
    |=> rx_pos_o == $past(rx_sync_reg[0]) && rx_neg_o == $past(rx_sync_reg[1]))
    else $error("dual-rail receive routing wrong");

  // Front-end controls
  build_out_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    wr_go && reg_idx == IDX_LINE_CTRL
    |=> tx_build_out_select_o == $past(avs_writedata_i[LC_TXL_LSB +: 3]))
    else $error("build-out select not taken from the write");
  eq_off_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    wr_go && reg_idx == IDX_LINE_CTRL
    |=> rx_equalizer_off_o == $past(avs_writedata_i[LC_EQ_OFF]))
    else $error("equalizer disable not taken from the write");
  eq_level_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    rx_equalizer_off_o |-> rx_equalization_level_o == line_ctrl_reg[LC_RES_LSB +: 3])
    else $error("forced level not passed through");
  eq_force_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !rx_equalizer_off_o |-> rx_equalization_level_o == 3'b000 && !rx_eq_forced_o)
    else $error("forced level active while equalizer automatic");

endmodule : tam_alarm_line_ctrl

// ---- testbench/tam_host_model.sv ----
// Avalon-MM master that stands in for the host software configuring the block.
// Assumes one clock shared with the slave and one access in flight at a time.
`timescale 1ns/10ps
module tam_host_model
  import tam_pkg::*;
(
  // Clock
  input  wire logic              ref_clk_i,
  // Avalon-MM master
  output logic      [ADDR_W-1:0] avs_address_o,
  output logic                   avs_read_o,
  output logic                   avs_write_o,
  output logic      [31:0]       avs_writedata_o,
  output logic      [3:0]        avs_byteenable_o,
  input  wire logic [31:0]       avs_readdata_i,
  input  wire logic              avs_waitrequest_i
);
  initial begin
    avs_address_o    = '0;
    avs_read_o       = 1'b0;
    avs_write_o      = 1'b0;
    avs_writedata_o  = 32'h0000_0000;
    avs_byteenable_o = 4'h1;
  end

  // Request held until waitrequest is seen low at a rising edge; read data taken there
  task automatic access(input logic wr, input logic [ADDR_W-1:0] addr,
                        input logic [7:0] data, output logic [31:0] rdata);
    @(posedge ref_clk_i);
    avs_address_o   <= addr;
    avs_write_o     <= wr;
    avs_read_o      <= !wr;
    avs_writedata_o <= {24'h00_0000, data};
    do begin
      @(posedge ref_clk_i);
    end while (avs_waitrequest_i !== 1'b0);
    rdata = avs_readdata_i;
    avs_read_o      <= 1'b0;
    avs_write_o     <= 1'b0;
    // Released data must not keep looking valid
    avs_writedata_o <= ~avs_writedata_o;
  endtask : access
endmodule : tam_host_model

// ---- testbench/tb_t1_alarm_mask_and_line_ctrl.sv ----
// Self-checking bench for the alarm mask and line front-end control bank.
// Assumes the host model issues every register access; event sources are driven here.
`timescale 1ns/10ps
module tb_t1_alarm_mask_and_line_ctrl
  import tam_pkg::*;
();
  // Short counts keep the loop and debounce waits brief
  localparam int LP = 20;
  localparam int DB = 8;
  localparam logic [ADDR_W-1:0] A_MASK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [ADDR_W-1:0] A_LINE = {IDX_LINE_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] A_STAT = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] A_MODE = {IDX_MODE_CTRL, 2'b00};
  logic              ref_clk, arst_n, read, write, waitreq, irq;
  logic [ADDR_W-1:0] address;
  logic [31:0]       wdata, rdata, rdq;
  logic [3:0]        be, sig_bits;
  logic              loop_on, one_sec, five_sec, bom_stb, tx_pos, tx_neg, in_first, in_second;
  logic [BOM_W-1:0]  bom_code;
  logic              rx_pos, rx_neg, out_first, out_second, liu_dis, eq_off, eq_forced;
  logic [2:0]        build_out, eq_level;
  int                errors = 0;
  int                compares = 0;

  always #10 ref_clk = ~ref_clk;

  tam_host_model host (.ref_clk_i(ref_clk), .avs_address_o(address), .avs_read_o(read),
    .avs_write_o(write), .avs_writedata_o(wdata), .avs_byteenable_o(be),
    .avs_readdata_i(rdata), .avs_waitrequest_i(waitreq));

  tam_alarm_line_ctrl #(.LOOP_CYCLES(LP), .DEBOUNCE_CYCLES(DB)) uut (
    .ref_clk_i(ref_clk), .arst_n_i(arst_n), .avs_address_i(address), .avs_read_i(read),
    .avs_write_i(write), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .loop_code_present_i(loop_on),
    .one_second_flag_i(one_sec), .five_second_flag_i(five_sec), .bom_strobe_i(bom_stb),
    .bom_code_i(bom_code), .sig_bits_i(sig_bits), .tx_pos_i(tx_pos), .tx_neg_i(tx_neg),
    .rx_pos_o(rx_pos), .rx_neg_o(rx_neg), .line_in_first_i(in_first),
    .line_in_second_i(in_second), .line_out_first_o(out_first),
    .line_out_second_o(out_second), .liu_disable_o(liu_dis),
    .tx_build_out_select_o(build_out), .rx_equalizer_off_o(eq_off),
    .rx_equalization_level_o(eq_level), .rx_eq_forced_o(eq_forced), .irq_o(irq));

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : step

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, rdq);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    host.access(1'b0, a, 8'h00, rdq);
  endtask : rd

  // Status records the event even when masked; only the request line follows the mask
  task automatic ev_chk(input int b, input logic hit);
    @(negedge ref_clk);
    chk("irq", irq, hit);
    rd(A_STAT);
    chk("status", rdq, 32'h0000_0001 << b);
    wr(A_STAT, 8'h1F);
    @(negedge ref_clk);
    chk("irq cleared", irq, 1'b0);
    step(1);
  endtask : ev_chk

  task automatic bom(input logic [BOM_W-1:0] code, input int n);
    repeat (n) begin
      bom_code <= code;
      bom_stb  <= 1'b1;
      step(1);
      bom_stb  <= 1'b0;
      step(2);
    end
  endtask : bom

  task automatic t_regs();
    rd(A_LINE);
    chk("line reset", rdq, 32'h0000_0000);
    chk("build-out reset", build_out, 3'h0);
    rd(10'h3FC);
    chk("unmapped", rdq, 32'h0000_0000);
    rd(A_MASK);
    chk("mask reset", rdq, 32'h0000_0000);
    wr(A_MASK, 8'hFF);
    rd(A_MASK);
    chk("mask unused", rdq, 32'h0000_001F);
    wr(A_MASK, 8'h00);
    one_sec <= 1'b1;
    step(3);
    ev_chk(EV_ONE, 1'b0);
    one_sec <= 1'b0;
  endtask : t_regs

  task automatic t_line();
    for (int c = 0; c < 8; c++) begin
      wr(A_LINE, {1'b0, c[2:0], 1'b1, c[2:0]});
      @(negedge ref_clk);
      chk("build-out", build_out, c[2:0]);
      chk("eq level", eq_level, c[2:0]);
      chk("eq off", eq_off, 1'b1);
      chk("eq forced", eq_forced, 1'b1);
    end
    wr(A_LINE, 8'h53);
    @(negedge ref_clk);
    chk("eq level ignored", eq_level, 3'h0);
    chk("eq not forced", eq_forced, 1'b0);
    chk("eq on", eq_off, 1'b0);
    rd(A_LINE);
    chk("line readback", rdq, 32'h0000_0053);
  endtask : t_line

  task automatic t_events();
    wr(A_MASK, 8'h1F);
    one_sec <= 1'b1;
    step(3);
    ev_chk(EV_ONE, 1'b1);
    five_sec <= 1'b1;
    step(3);
    ev_chk(EV_FIVE, 1'b1);
    five_sec <= 1'b0;
    loop_on  <= 1'b1;
    step(LP - 4);
    @(negedge ref_clk);
    chk("loop early", irq, 1'b0);
    step(8);
    ev_chk(EV_LOOP, 1'b1);
    loop_on  <= 1'b0;
    sig_bits <= 4'h5;
    step(3);
    ev_chk(EV_SIG, 1'b1);
    wr(A_MODE, 8'h01);
    sig_bits <= 4'hA;
    step(DB - 4);
    @(negedge ref_clk);
    chk("debounce early", irq, 1'b0);
    step(8);
    ev_chk(EV_SIG, 1'b1);
  endtask : t_events

  // Two foreign codes sit in the window, so the eighth match is the first acceptance
  task automatic t_bom();
    bom(6'h15, 2);
    bom(6'h2A, 7);
    @(negedge ref_clk);
    chk("bom seven", irq, 1'b0);
    step(1);
    bom(6'h2A, 1);
    ev_chk(EV_BOM, 1'b1);
    bom(6'h2A, 10);
    @(negedge ref_clk);
    chk("bom repeat", irq, 1'b0);
  endtask : t_bom

  task automatic t_pins();
    {in_first, in_second, tx_pos, tx_neg} <= 4'hF;
    step(5);
    @(negedge ref_clk);
    chk("idle rx pos", rx_pos, 1'b0);
    chk("idle out second", out_second, 1'b0);
    chk("liu enabled", liu_dis, 1'b0);
    wr(A_MODE, 8'h02);
    wr(A_LINE, 8'h80);
    step(5);
    @(negedge ref_clk);
    chk("liu disabled", liu_dis, 1'b1);
    chk("nrz rx pos", rx_pos, 1'b1);
    chk("nrz rx neg", rx_neg, 1'b0);
    chk("nrz out first", out_first, 1'b0);
    chk("nrz out second", out_second, 1'b1);
    wr(A_LINE, 8'h00);
    {in_first, tx_pos} <= 2'h0;
    step(5);
    @(negedge ref_clk);
    chk("dual rx pos", rx_pos, 1'b0);
    chk("dual rx neg", rx_neg, 1'b1);
    chk("dual out first", out_first, 1'b0);
    chk("dual out second", out_second, 1'b1);
  endtask : t_pins

  task automatic end_of_test();
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  initial begin
    ref_clk  = 1'b0;
    arst_n   = 1'b0;
    {loop_on, one_sec, five_sec, bom_stb, tx_pos, tx_neg, in_first, in_second} = '0;
    bom_code = '0;
    sig_bits = 4'h0;
    step(3);
    arst_n <= 1'b1;
    t_regs();
    t_line();
    t_events();
    t_bom();
    t_pins();
    end_of_test();
  end

  initial begin
    step(5000);
    errors++;
    end_of_test();
  end
endmodule : tb_t1_alarm_mask_and_line_ctrl
